// ===== light_flag_pkg.sv
// Functional notes
// - Transparent: high run sets alert, high flag
// - Transparent: low run sets low; clears alert outside end-of-conversion
// - Transparent: config access leaves flags; alert too outside end-of-conversion
// - Transparent: alert response is ignored entirely
// - Low limit top bits 11: end-of-conversion
// - Each conversion sets ready; misses keep flags
// - Config read clears conversion ready
// - Shutdown write changes no indication
// - Non-shutdown write clears ready; alert too in transparent end-of-conversion
// - Alert pin low per sense select
// - Config bit 4 picks latched or transparent
// - Latched: fault run latches flag, alert
// - Latched: config read clears alert, flags
// - Latched: alert response clears alert only
package light_flag_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  // Register offsets
  localparam logic [7:0] RESULT_OFS = 8'h00;
  localparam logic [7:0] CFG_OFS = 8'h01;
  localparam logic [7:0] LOW_OFS = 8'h02;
  localparam logic [7:0] HIGH_OFS = 8'h03;
  localparam logic [7:0] PIN_OFS = 8'h04;
  // Configuration field positions
  localparam int FAULT_LSB = 0;
  localparam int MASK_EXP_BIT = 2;
  localparam int SENSE_BIT = 3;
  localparam int WINDOW_BIT = 4;
  localparam int FLAG_LO_BIT = 5;
  localparam int FLAG_HI_BIT = 6;
  localparam int READY_BIT = 7;
  localparam int OVF_BIT = 8;
  localparam int OP_LSB = 9;
  localparam int CT_BIT = 11;
  localparam int RANGE_LSB = 12;
  localparam int LOW_EXP_LSB = 14;
  // Read-only bits of the configuration word
  localparam logic [15:0] CFG_RO_MASK = 16'h01E0;
  localparam logic [1:0] OP_SHUTDOWN = 2'h0;
  localparam logic [1:0] LOW_EXP_EOC = 2'h3;
  // Reset values
  localparam logic [15:0] CFG_RST = 16'hC810;
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [15:0] HIGH_RST = 16'hBFFF;
  // Consecutive fault counts per fault field code
  localparam logic [3:0] FAULT_N0 = 4'h1;
  localparam logic [3:0] FAULT_N1 = 4'h2;
  localparam logic [3:0] FAULT_N2 = 4'h4;
  localparam logic [3:0] FAULT_N3 = 4'h8;
endpackage

// ===== light_threshold_flag_logic.sv
`timescale 1ns/10ps
module light_threshold_flag_logic import light_flag_pkg::*; (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  input wire logic conv_done_in,
  input wire logic [DATA_W-1:0] result_in,
  input wire logic alert_resp_in,
  output logic alert_resp_ack_out,
  input wire logic alert_pin_in,
  output logic alert_pin_out,
  output logic alert_pin_oe_n_out,
  output logic [1:0] op_mode_out,
  output logic [3:0] range_out,
  output logic conv_time_out
);
  logic [15:0] cfg_r;
  logic [15:0] low_r;
  logic [15:0] high_r;
  logic [15:0] result_r;
  // Indication state and its next value
  logic flag_hi_r;
  logic flag_lo_r;
  logic ready_r;
  logic alert_r;
  logic flag_hi_nxt;
  logic flag_lo_nxt;
  logic ready_nxt;
  logic alert_nxt;
  // Fault runs: bit 0 for the high limit, bit 1 for the low limit
  logic [1:0] fault_now;
  logic [1:0] run_met;
  logic [15:0] rdata_r;
  logic pin_meta_r, pin_sync_r;
  logic oe_n_r;
  logic ack_r;

  // Address decode
  wire cfg_sel = (addr_in == CFG_OFS);
  wire cfg_rd = rd_in & cfg_sel;
  wire cfg_wr = wr_in & cfg_sel;
  wire [1:0] wr_op = wdata_in[OP_LSB+1:OP_LSB];
  wire wr_run = cfg_wr & (wr_op != OP_SHUTDOWN);
  wire window_mode = cfg_r[WINDOW_BIT];
  wire sense = cfg_r[SENSE_BIT];
  // Sense as it stands after this edge, so pin and state move together
  wire sense_nxt = cfg_wr ? wdata_in[SENSE_BIT] : sense;
  wire low_wr = wr_in & (addr_in == LOW_OFS);
  wire high_wr = wr_in & (addr_in == HIGH_OFS);
  wire eoc_mode = (low_r[LOW_EXP_LSB+1:LOW_EXP_LSB] == LOW_EXP_EOC);
  wire resp_take = alert_resp_in & window_mode & alert_r;

  // Fault count needed from the fault field
  wire [1:0] fault_code = cfg_r[FAULT_LSB+1:FAULT_LSB];
  wire [3:0] fault_need = (fault_code == 2'h0) ? FAULT_N0 :
                          (fault_code == 2'h1) ? FAULT_N1 :
                          (fault_code == 2'h2) ? FAULT_N2 : FAULT_N3;

  // Limit comparisons on the fresh result, strict on both sides
  assign fault_now[0] = (result_in > high_r);
  assign fault_now[1] = (result_in < low_r);

  // One saturating run counter per limit
  for (genvar i = 0; i < 2; i++) begin : g_run
    logic [3:0] cnt_r;
    // Saturate at the longest run so the count never wraps
    wire [3:0] cnt_inc = (cnt_r >= FAULT_N3) ? FAULT_N3 : cnt_r + 4'h1;
    // A conversion inside the limit restarts the run
    wire [3:0] cnt_run = fault_now[i] ? cnt_inc : 4'h0;
    wire [3:0] cnt_nxt = conv_done_in ? cnt_run : cnt_r;
    // Met on the conversion that completes the run
    assign run_met[i] = conv_done_in & (cnt_run >= fault_need);

    // Run count register, advances on conversions only
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  wire hit_hi = run_met[0];
  wire hit_lo = run_met[1];

  // Conversion ready: set wins over clear
  always_comb begin
    ready_nxt = ready_r;
    if (cfg_rd) begin
      ready_nxt = 1'h0;
    end
    if (wr_run) begin
      ready_nxt = 1'h0;
    end
    if (conv_done_in) begin
      ready_nxt = 1'h1;
    end
  end

  // Flags and alert state per mode
  always_comb begin
    flag_hi_nxt = flag_hi_r;
    flag_lo_nxt = flag_lo_r;
    alert_nxt = alert_r;
    if (window_mode) begin
      // Latched window: clears first, so new faults win
      if (cfg_rd) begin
        flag_hi_nxt = 1'h0;
        flag_lo_nxt = 1'h0;
        alert_nxt = 1'h0;
      end
      if (resp_take) begin
        alert_nxt = 1'h0;
      end
      if (eoc_mode && conv_done_in) begin
        alert_nxt = 1'h1;
      end
      if (hit_hi) begin
        flag_hi_nxt = 1'h1;
        alert_nxt = 1'h1;
      end
      if (hit_lo) begin
        flag_lo_nxt = 1'h1;
        alert_nxt = 1'h1;
      end
    end else if (eoc_mode) begin
      // Transparent flags, alert marks each conversion
      if (cfg_rd || wr_run) begin
        alert_nxt = 1'h0;
      end
      if (conv_done_in) begin
        alert_nxt = 1'h1;
      end
      if (hit_hi) begin
        flag_hi_nxt = 1'h1;
        flag_lo_nxt = 1'h0;
      end else if (hit_lo) begin
        flag_hi_nxt = 1'h0;
        flag_lo_nxt = 1'h1;
      end
    end else begin
      // Transparent: config access has no effect here
      if (hit_hi) begin
        alert_nxt = 1'h1;
        flag_hi_nxt = 1'h1;
        flag_lo_nxt = 1'h0;
      end else if (hit_lo) begin
        alert_nxt = 1'h0;
        flag_hi_nxt = 1'h0;
        flag_lo_nxt = 1'h1;
      end
    end
  end

  // Read data mux
  wire [15:0] cfg_view = {cfg_r[15:8], ready_r, flag_hi_r, flag_lo_r,
                          cfg_r[4:0]};
  wire [15:0] pin_view = {15'h0000, pin_sync_r};
  wire result_sel = (addr_in == RESULT_OFS);
  wire low_sel = (addr_in == LOW_OFS);
  wire high_sel = (addr_in == HIGH_OFS);
  wire pin_sel = (addr_in == PIN_OFS);
  // Unmapped offsets read as zero
  wire [15:0] rd_mux = result_sel ? result_r :
                       cfg_sel ? cfg_view :
                       low_sel ? low_r :
                       high_sel ? high_r :
                       pin_sel ? pin_view : 16'h0000;

  // Pin drive low: active with sense 0 or idle with sense 1
  wire drive_low = alert_nxt ^ sense_nxt;

  // Writable configuration bits; shutdown write only stores fields
  wire [15:0] cfg_wval = (wdata_in & ~CFG_RO_MASK) | (cfg_r & CFG_RO_MASK);

  // Register file
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_r <= CFG_RST;
      low_r <= LOW_RST;
      high_r <= HIGH_RST;
    end else begin
      if (cfg_wr) begin
        cfg_r <= cfg_wval;
      end
      if (low_wr) begin
        low_r <= wdata_in;
      end
      if (high_wr) begin
        high_r <= wdata_in;
      end
    end
  end

  // Result capture
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result_r <= 16'h0000;
    end else if (conv_done_in) begin
      result_r <= result_in;
    end
  end

  // Indication state
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flag_hi_r <= 1'h0;
      flag_lo_r <= 1'h0;
      ready_r <= 1'h0;
      alert_r <= 1'h0;
    end else begin
      flag_hi_r <= flag_hi_nxt;
      flag_lo_r <= flag_lo_nxt;
      ready_r <= ready_nxt;
      alert_r <= alert_nxt;
    end
  end

  // Pin enable, response ack, read data
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      oe_n_r <= 1'h1;
      ack_r <= 1'h0;
      rdata_r <= 16'h0000;
    end else begin
      oe_n_r <= ~drive_low;
      ack_r <= resp_take;
      rdata_r <= rd_in ? rd_mux : 16'h0000;
    end
  end

  // Pin level synchroniser
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // Start at the pulled-up idle level of the wire
      pin_meta_r <= 1'h1;
      pin_sync_r <= 1'h1;
    end else begin
      pin_meta_r <= alert_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Bus, pin and response outputs
  assign rdata_out = rdata_r;
  assign alert_pin_out = 1'h0; // Open drain: only ever pulls low
  assign alert_pin_oe_n_out = oe_n_r;
  assign alert_resp_ack_out = ack_r;
  // Converter control fields straight from the configuration
  assign op_mode_out = cfg_r[OP_LSB+1:OP_LSB];
  assign range_out = cfg_r[RANGE_LSB+3:RANGE_LSB];
  assign conv_time_out = cfg_r[CT_BIT];
endmodule // light_threshold_flag_logic

// ===== alert_wire_model.sv
`timescale 1ns/10ps
module alert_wire_model (
  input wire logic oe_n_in,
  input wire logic drive_in,
  output logic level_out
);
  // Pull-up holds the wire high while released
  assign level_out = oe_n_in ? 1'b1 : drive_in;
endmodule // alert_wire_model

// ===== flag_props.sv
`timescale 1ns/10ps
module flag_props import light_flag_pkg::*; (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [DATA_W-1:0] rdata_out,
  input wire logic conv_done_in,
  input wire logic alert_resp_in,
  input wire logic alert_resp_ack_out,
  input wire logic alert_pin_out,
  input wire logic alert_pin_oe_n_out
);
  logic [2:0] mode_r;
  logic [2:0] mode_nxt;
  logic cfg_wr;
  logic cfg_rd;
  logic quiet;
  // Shadow of end-of-conversion, window and sense choices
  assign cfg_wr = wr_in && addr_in == CFG_OFS;
  assign cfg_rd = rd_in && addr_in == CFG_OFS;
  assign quiet = !conv_done_in && !alert_resp_in;
  assign mode_nxt[2] = (wr_in && addr_in == LOW_OFS) ?
    wdata_in[15:14] == LOW_EXP_EOC : mode_r[2];
  assign mode_nxt[1:0] = cfg_wr ?
    {wdata_in[WINDOW_BIT], wdata_in[SENSE_BIT]} : mode_r[1:0];
  // Shadow register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_r <= {1'b0, CFG_RST[WINDOW_BIT], CFG_RST[SENSE_BIT]};
    end else begin
      mode_r <= mode_nxt;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  resp_ignored_a: assert property (alert_resp_in && !mode_r[1]
    && !conv_done_in && !wr_in && !rd_in
    |=> !alert_resp_ack_out && $stable(alert_pin_oe_n_out))
    else $error("alert response taken in transparent mode");
  ack_clears_a: assert property (alert_resp_ack_out
    && !$past(conv_done_in) |-> alert_pin_oe_n_out == !mode_r[0])
    else $error("alert left active after response");
  pin_drive_a: assert property (alert_pin_out == 1'b0)
    else $error("alert pin drives high");
  wr_keeps_a: assert property (cfg_wr && quiet && !mode_r[2]
    && wdata_in[SENSE_BIT] == mode_r[0] && wdata_in[WINDOW_BIT] == mode_r[1]
    |=> $stable(alert_pin_oe_n_out))
    else $error("config write moved the alert");
  rd_clears_a: assert property (cfg_rd && mode_r[1] && quiet
    |=> alert_pin_oe_n_out == !mode_r[0])
    else $error("latched alert kept after config read");
  trans_rd_keeps_a: assert property (cfg_rd && !mode_r[1]
    && !mode_r[2] && quiet |=> $stable(alert_pin_oe_n_out))
    else $error("transparent alert moved on read");
  alert_cause_a: assert property (!$stable(alert_pin_oe_n_out)
    |-> $past(conv_done_in || wr_in || rd_in || alert_resp_in))
    else $error("alert moved without a cause");
  ready_once_a: assert property (cfg_rd && !conv_done_in ##1
    cfg_rd && !conv_done_in |=> rdata_out[READY_BIT] == 1'b0)
    else $error("second read still shows ready");
  cover property (alert_resp_ack_out);
  cover property (cfg_rd && !alert_pin_oe_n_out);
  cover property (conv_done_in ##1 !alert_pin_oe_n_out);
endmodule // flag_props
bind light_threshold_flag_logic flag_props u_props (.clk_in(clk_in),
  .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .conv_done_in(conv_done_in), .alert_resp_in(alert_resp_in),
  .alert_resp_ack_out(alert_resp_ack_out), .alert_pin_out(alert_pin_out),
  .alert_pin_oe_n_out(alert_pin_oe_n_out));

// ===== testbench.sv
`timescale 1ns/10ps
module testbench import light_flag_pkg::*;;
  logic clk, arst_n, wr, rd, conv, resp, ack, pin_o, oe_n, ct, lvl;
  logic [7:0] addr;
  logic [15:0] wdata, result, rdata;
  logic [1:0] op;
  logic [3:0] rng;
  int fails, n_checks, cyc;
  light_threshold_flag_logic DUT (.clk_in(clk), .arst_n_in(arst_n),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .conv_done_in(conv), .result_in(result),
    .alert_resp_in(resp), .alert_resp_ack_out(ack), .alert_pin_in(lvl),
    .alert_pin_out(pin_o), .alert_pin_oe_n_out(oe_n), .op_mode_out(op),
    .range_out(rng), .conv_time_out(ct));
  alert_wire_model wire_m (.oe_n_in(oe_n), .drive_in(pin_o), .level_out(lvl));
  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      final_report;
    end
  end
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  // Two back-to-back reads of one offset
  task automatic rd2_chk(input logic [7:0] a, input logic [15:0] e1,
    input logic [15:0] e2);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    #1;
    chk("rdata", e1, rdata);
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e2, rdata);
  endtask
  // Conversion or alert response pulse, then alert and ack compare
  task automatic pulse(input logic is_resp, input logic [15:0] r,
    input logic e_ack, input logic e_oe);
    @(posedge clk);
    conv <= !is_resp;
    resp <= is_resp;
    result <= r;
    @(posedge clk);
    conv <= 1'b0;
    resp <= 1'b0;
    #1;
    chk("ack", e_ack, ack);
    chk("oe_n", e_oe, oe_n);
  endtask
  task automatic final_report;
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk = 0;
    {arst_n, wr, rd, conv, resp, addr, wdata, result} = '0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(CFG_OFS, CFG_RST);
    rd_chk(HIGH_OFS, HIGH_RST);
    rd_chk(8'h20, 16'h0000);
    rd_chk(PIN_OFS, 16'h0001);
    // Latched window: broken run, full run, read clears
    wr_reg(LOW_OFS, 16'h0100);
    wr_reg(HIGH_OFS, 16'h0800);
    wr_reg(CFG_OFS, 16'hCA11);
    chk("op_mode", 16'h0001, op);
    chk("range", 16'h000C, rng);
    chk("conv_time", 16'h0001, ct);
    pulse(0, 16'h0900, 0, 1);
    pulse(0, 16'h0400, 0, 1);
    pulse(0, 16'h0900, 0, 1);
    pulse(0, 16'h0900, 0, 0);
    rd_chk(CFG_OFS, 16'hCAD1);
    chk("oe_n", 1, oe_n);
    rd_chk(CFG_OFS, 16'hCA11);
    // Low latch, shutdown write, alert response
    pulse(0, 16'h0010, 0, 1);
    pulse(0, 16'h0010, 0, 0);
    wr_reg(CFG_OFS, 16'hC811);
    chk("oe_n", 0, oe_n);
    pulse(1, 16'h0000, 1, 1);
    rd_chk(CFG_OFS, 16'hC8B1);
    // Transparent hysteresis
    wr_reg(CFG_OFS, 16'hCA01);
    pulse(0, 16'h0900, 0, 1);
    pulse(0, 16'h0900, 0, 0);
    wr_reg(CFG_OFS, 16'hCA01);
    rd_chk(CFG_OFS, 16'hCA41);
    chk("oe_n", 0, oe_n);
    pulse(1, 16'h0000, 0, 0);
    pulse(0, 16'h0400, 0, 0);
    pulse(0, 16'h0010, 0, 0);
    pulse(0, 16'h0010, 0, 1);
    rd2_chk(CFG_OFS, 16'hCAA1, 16'hCA21);
    // Inactive alert with high sense pulls the wire
    wr_reg(CFG_OFS, 16'hCA09);
    repeat (2) @(posedge clk);
    #1;
    chk("wire", 0, lvl);
    rd_chk(PIN_OFS, 16'h0000);
    // End-of-conversion: in-range result still raises alert
    wr_reg(CFG_OFS, 16'hCA11);
    wr_reg(HIGH_OFS, 16'hFFFF);
    wr_reg(LOW_OFS, 16'hC000);
    chk("oe_n", 1, oe_n);
    pulse(0, 16'hD000, 0, 0);
    final_report;
  end
endmodule // testbench
